// ==== hdl/spg_defs.svh ====
`ifndef SPG_DEFS_SVH
`define SPG_DEFS_SVH

// special-function window of the direct address space
`define SPG_SFR_LO 8'h80
`define SPG_SFR_HI 8'hFF
// stack and control register addresses
`define SPG_ADDR_SELECT 8'hA7
`define SPG_ADDR_MIDDLE 8'h85
`define SPG_ADDR_BOTTOM 8'h86
`define SPG_ADDR_CONTROL 8'h8E
// implemented pages
`define SPG_PAGE_BASE 8'h00
`define SPG_PAGE_EXT 8'h0F
// page control lives on this page
`define SPG_PAGE_CONTROL 8'h0F
// reset values
`define SPG_RST_SELECT 8'h00
`define SPG_RST_MIDDLE 8'h00
`define SPG_RST_BOTTOM 8'h00
`define SPG_RST_CONTROL 8'h01
// value placed in the middle entry when the bottom holds nothing
`define SPG_EMPTY_PAGE 8'h00
// field positions
`define SPG_BIT_AUTO_EN 0
// low nibbles of bit-addressable registers
`define SPG_NIB_BIT0 4'h0
`define SPG_NIB_BIT8 4'h8

`endif

// ==== hdl/spg_pkg.sv ====
package spg_pkg;
  // target of a decoded direct access
  typedef enum logic [2:0] {
    SPG_TGT_RAM,
    SPG_TGT_SELECT,
    SPG_TGT_MIDDLE,
    SPG_TGT_BOTTOM,
    SPG_TGT_CONTROL,
    SPG_TGT_PERIPH
  } spg_target_e;
  // stack action for one cycle
  typedef enum logic [1:0] {
    SPG_ACT_HOLD,
    SPG_ACT_PUSH,
    SPG_ACT_POP
  } spg_action_e;
  typedef logic [7:0] spg_byte_t;
endpackage

// ==== hdl/spg_stack_entry.sv ====
`timescale 1ns/1ps
// one byte of the page stack: software write, or load on stack movement
module spg_stack_entry
  import spg_pkg::*;
#(
  parameter spg_byte_t RST_VAL = 8'h00
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // software write port
  input wire logic sw_we,
  input wire spg_byte_t sw_data,
  // hardware load port, wins over software
  input wire logic hw_load,
  input wire spg_byte_t hw_data,
  // stored value
  output spg_byte_t value_r
);
  // hardware stack movement wins over a same-cycle software write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      value_r <= RST_VAL;
    end else if (hw_load) begin
      value_r <= hw_data;
    end else if (sw_we) begin
      value_r <= sw_data;
    end
  end
endmodule

// ==== hdl/spg_sfr_pager.sv ====
`timescale 1ns/1ps
`include "spg_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - direct addresses 0x80-0xFF go to SFR space
// - low nibble 0 or 8 allows bit access
// - other addresses accept byte access only
// - eight-bit page number selects among 256 pages
// - paged registers exist on pages 0x00, 0x0F
// - entry pushes: middle to bottom, select to middle
// - return pops: middle to select, bottom to middle
// - empty bottom pops 0x00 into middle
// - each stack level has own read/write register
// - software writes never push or pop
// - pop restores software-written middle and bottom
// - push overwrites software-written bottom entry
// - auto paging loads interrupt page after push
// - auto enable is control bit 0, resets 1
// - cleared enable: no page switch, no push/pop
// - control bits 7:1 read zero, ignore writes
// - all-page registers ignore the page select
// - page select writable in any cycle without a push or pop, effective next access
// - page select at 0xA7, all pages
// - middle entry at 0x85, all pages
// - bottom entry at 0x86, all pages
module spg_sfr_pager
  import spg_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // direct access from the core
  input wire logic acc_direct,
  input wire logic acc_write,
  input wire logic acc_read,
  input wire logic acc_bit,
  input wire logic [7:0] acc_addr,
  input wire logic [2:0] acc_bit_pos,
  input wire logic [7:0] acc_wdata,
  // interrupt events from the core
  input wire logic int_entry,
  input wire logic interrupt_return,
  input wire logic [7:0] int_page,
  // read data and decode results
  output logic [7:0] acc_rdata_r,
  output logic sfr_sel_r,
  output logic ram_sel_r,
  output logic bit_ok_r,
  output logic bit_refused_r,
  output logic periph_sel_r,
  output logic [7:0] periph_page_r,
  output logic [7:0] periph_addr_r,
  output logic page_known_r,
  // stack view
  output logic [7:0] page_select_r,
  output logic [7:0] page_stack_middle_r,
  output logic [7:0] page_stack_bottom_r,
  output logic auto_page_enable_r
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  // any direct access inside the window targets SFR space
  wire in_sfr = acc_direct && (acc_addr >= `SPG_SFR_LO);
  // bit access only where the low nibble is 0 or 8
  wire bit_addr = (acc_addr[3:0] == `SPG_NIB_BIT0) ||
                  (acc_addr[3:0] == `SPG_NIB_BIT8);
  // bit request on a byte-only address is dropped
  wire bit_bad = in_sfr && acc_bit && !bit_addr;
  wire op_ok = in_sfr && !bit_bad;
  // stack registers decode on every page
  wire hit_sel = (acc_addr == `SPG_ADDR_SELECT);
  wire hit_mid = (acc_addr == `SPG_ADDR_MIDDLE);
  wire hit_bot = (acc_addr == `SPG_ADDR_BOTTOM);
  // control register only on its own page
  wire hit_ctl = (acc_addr == `SPG_ADDR_CONTROL) &&
                 (page_select_r == `SPG_PAGE_CONTROL);
  wire hit_own = hit_sel || hit_mid || hit_bot || hit_ctl;
  // current page is one that holds paged registers
  wire page_impl = (page_select_r == `SPG_PAGE_BASE) ||
                   (page_select_r == `SPG_PAGE_EXT);

  // decoded target, drives the write enables
  spg_target_e target;
  assign target = !in_sfr ? SPG_TGT_RAM :
                  hit_sel ? SPG_TGT_SELECT :
                  hit_mid ? SPG_TGT_MIDDLE :
                  hit_bot ? SPG_TGT_BOTTOM :
                  hit_ctl ? SPG_TGT_CONTROL : SPG_TGT_PERIPH;

  ////////////////////////////////////////////////////////////////////////////
  // write data with bit merge

  // current byte of the addressed own register
  wire [7:0] own_val = hit_sel ? page_select_r :
                       hit_mid ? page_stack_middle_r :
                       hit_bot ? page_stack_bottom_r :
                       hit_ctl ? {7'h00, auto_page_enable_r} : 8'h00;
  // single bit write merges into the current value
  wire [7:0] bit_mask = 8'h01 << acc_bit_pos;
  wire [7:0] wr_byte = acc_bit ? ((own_val & ~bit_mask) |
                                  (acc_wdata[0] ? bit_mask : 8'h00))
                               : acc_wdata;
  wire wr_ok = acc_write && op_ok;
  wire we_sel = wr_ok && (target == SPG_TGT_SELECT);
  wire we_mid = wr_ok && (target == SPG_TGT_MIDDLE);
  wire we_bot = wr_ok && (target == SPG_TGT_BOTTOM);
  wire we_ctl = wr_ok && (target == SPG_TGT_CONTROL);

  ////////////////////////////////////////////////////////////////////////////
  // stack control

  // stack moves only on core events, gated by the enable; entry first
  spg_action_e action;
  assign action = !auto_page_enable_r ? SPG_ACT_HOLD :
                  int_entry ? SPG_ACT_PUSH :
                  interrupt_return ? SPG_ACT_POP : SPG_ACT_HOLD;
  wire do_push = (action == SPG_ACT_PUSH);
  wire do_pop = (action == SPG_ACT_POP);
  // bottom counts as empty once popped until a push or a software write refills it
  logic bot_full_r;
  logic bot_full_nxt;
  // a software write to the bottom in a pop cycle still leaves it full
  assign bot_full_nxt = do_push ? 1'b1 :
                        we_bot ? 1'b1 :
                        do_pop ? 1'b0 : bot_full_r;

  // new value for each entry on stack movement
  wire [7:0] sel_hw = do_push ? int_page : page_stack_middle_r;
  wire [7:0] mid_hw = do_push ? page_select_r :
                      (bot_full_r ? page_stack_bottom_r : `SPG_EMPTY_PAGE);
  wire [7:0] bot_hw = page_stack_middle_r;
  wire mv = do_push || do_pop;

  ////////////////////////////////////////////////////////////////////////////
  // stack entries

  // top of stack, the page select
  spg_stack_entry #(.RST_VAL(`SPG_RST_SELECT)) u_select (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .sw_we(we_sel),
    .sw_data(wr_byte),
    .hw_load(mv),
    .hw_data(sel_hw),
    .value_r(page_select_r)
  );
  // middle entry
  spg_stack_entry #(.RST_VAL(`SPG_RST_MIDDLE)) u_middle (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .sw_we(we_mid),
    .sw_data(wr_byte),
    .hw_load(mv),
    .hw_data(mid_hw),
    .value_r(page_stack_middle_r)
  );
  // bottom entry, loaded only on push
  spg_stack_entry #(.RST_VAL(`SPG_RST_BOTTOM)) u_bottom (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .sw_we(we_bot),
    .sw_data(wr_byte),
    .hw_load(do_push),
    .hw_data(bot_hw),
    .value_r(page_stack_bottom_r)
  );

  // bottom occupancy flag
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bot_full_r <= 1'b0;
    end else begin
      bot_full_r <= bot_full_nxt;
    end
  end

  // reset byte of the control register, only the enable bit is kept
  localparam logic [7:0] CTL_RST = `SPG_RST_CONTROL;

  // control register, only bit 0 stored
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      auto_page_enable_r <= CTL_RST[`SPG_BIT_AUTO_EN];
    end else if (we_ctl) begin
      auto_page_enable_r <= wr_byte[`SPG_BIT_AUTO_EN];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered answers

  // read byte or bit of an own register, zero elsewhere
  wire [7:0] rd_val = acc_bit ? {7'h00, own_val[acc_bit_pos]} : own_val;

  // decode outputs registered one cycle after the request
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_rdata_r <= 8'h00;
      sfr_sel_r <= 1'b0;
      ram_sel_r <= 1'b0;
      bit_ok_r <= 1'b0;
      bit_refused_r <= 1'b0;
      periph_sel_r <= 1'b0;
      periph_page_r <= 8'h00;
      periph_addr_r <= 8'h00;
      page_known_r <= 1'b0;
    end else begin
      acc_rdata_r <= (acc_read && op_ok) ? rd_val : 8'h00;
      sfr_sel_r <= in_sfr && (acc_read || acc_write);
      ram_sel_r <= acc_direct && !in_sfr && (acc_read || acc_write);
      bit_ok_r <= in_sfr && acc_bit && bit_addr;
      bit_refused_r <= bit_bad && (acc_read || acc_write);
      periph_sel_r <= op_ok && !hit_own && (acc_read || acc_write);
      periph_page_r <= page_select_r;
      periph_addr_r <= acc_addr;
      page_known_r <= page_impl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_push_ev;
    auto_page_enable_r && int_entry;
  endsequence
  sequence s_pop_ev;
    auto_page_enable_r && !int_entry && interrupt_return;
  endsequence

  property p_push_mid;
    @(posedge sys_clk) disable iff (!rst_n)
    s_push_ev |=> page_stack_middle_r == $past(page_select_r);
  endproperty
  a_push_mid: assert property (p_push_mid) else $error("push lost select");

  property p_push_bot;
    @(posedge sys_clk) disable iff (!rst_n)
    s_push_ev |=> page_stack_bottom_r == $past(page_stack_middle_r);
  endproperty
  a_push_bot: assert property (p_push_bot) else $error("push lost middle");

  property p_auto_page;
    @(posedge sys_clk) disable iff (!rst_n)
    s_push_ev |=> page_select_r == $past(int_page);
  endproperty
  a_auto_page: assert property (p_auto_page) else $error("no auto page");

  property p_pop_sel;
    @(posedge sys_clk) disable iff (!rst_n)
    s_pop_ev |=> page_select_r == $past(page_stack_middle_r);
  endproperty
  a_pop_sel: assert property (p_pop_sel) else $error("pop select wrong");

  property p_pop_empty;
    @(posedge sys_clk) disable iff (!rst_n)
    s_pop_ev ##0 !bot_full_r |=> page_stack_middle_r == `SPG_EMPTY_PAGE;
  endproperty
  a_pop_empty: assert property (p_pop_empty) else $error("empty pop not zero");

  property p_disabled;
    @(posedge sys_clk) disable iff (!rst_n)
    !auto_page_enable_r && !we_sel && !we_mid |=> $stable(page_select_r) &&
      $stable(page_stack_middle_r);
  endproperty
  a_disabled: assert property (p_disabled) else $error("stack moved disabled");

  property p_sw_nomove;
    @(posedge sys_clk) disable iff (!rst_n)
    we_bot && !int_entry && !interrupt_return |=> $stable(page_select_r);
  endproperty
  a_sw_nomove: assert property (p_sw_nomove) else $error("write moved stack");

  property p_bit_refuse;
    @(posedge sys_clk) disable iff (!rst_n)
    in_sfr && acc_bit && acc_addr[2:0] != 3'h0 && acc_read |=> bit_refused_r && !bit_ok_r;
  endproperty
  a_bit_refuse: assert property (p_bit_refuse) else $error("bit not refused");

  property p_ctl_read;
    @(posedge sys_clk) disable iff (!rst_n)
    acc_read && !acc_bit && op_ok && hit_ctl |=> acc_rdata_r[7:1] == 7'h00;
  endproperty
  a_ctl_read: assert property (p_ctl_read) else $error("control high bits");

  // a pop from a filled bottom hands the stored bottom value to the middle
  property p_pop_restore;
    @(posedge sys_clk) disable iff (!rst_n)
    s_pop_ev ##0 bot_full_r |=> page_stack_middle_r == $past(page_stack_bottom_r);
  endproperty
  a_pop_restore: assert property (p_pop_restore) else $error("pop lost bottom");

  // direct accesses below the window go to data memory, never to SFR space
  property p_ram_route;
    @(posedge sys_clk) disable iff (!rst_n)
    acc_direct && acc_read && acc_addr < `SPG_SFR_LO |=> ram_sel_r && !sfr_sel_r;
  endproperty
  a_ram_route: assert property (p_ram_route) else $error("low address not ram");
endmodule

// ==== bench/spg_core_model.sv ====
`timescale 1ns/1ps
// core side: issues direct accesses and interrupt events
module spg_core_model (
  // clock
  input wire logic sys_clk,
  // direct access
  output logic acc_direct,
  output logic acc_write,
  output logic acc_read,
  output logic acc_bit,
  output logic [7:0] acc_addr,
  output logic [2:0] acc_bit_pos,
  output logic [7:0] acc_wdata,
  // interrupt events
  output logic int_entry,
  output logic interrupt_return,
  output logic [7:0] int_page
);
  ////////////////////////////////////////////////////////////////////////////////
  // idle at time zero
  initial begin
    {acc_direct, acc_write, acc_read, acc_bit, int_entry, interrupt_return} = 6'h00;
    {acc_addr, acc_wdata, int_page} = 24'h000000;
    acc_bit_pos = 3'h0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one direct access, held across exactly one sampling edge
  // absent addresses are used as well as occupied ones, page select is written first by the caller
  task automatic access(input logic w, input logic b, input logic [7:0] a,
                        input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    {acc_direct, acc_write, acc_read, acc_bit} = {1'b1, w, ~w, b};
    acc_addr = a;
    acc_wdata = d;
    acc_bit_pos = d[2:0];
    @(posedge sys_clk);
    #1;
    {acc_direct, acc_write, acc_read, acc_bit} = 4'h0;
    // released bus shows a changing value, never the old one
    acc_addr = ~a;
    acc_wdata = ~d;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // single-cycle interrupt entry carrying the source page
  task automatic entry(input logic [7:0] p);
    @(posedge sys_clk);
    #1;
    int_entry = 1'b1;
    int_page = p;
    @(posedge sys_clk);
    #1;
    int_entry = 1'b0;
    int_page = ~p;
  endtask

  // single-cycle interrupt return
  task automatic ret;
    @(posedge sys_clk);
    #1;
    interrupt_return = 1'b1;
    @(posedge sys_clk);
    #1;
    interrupt_return = 1'b0;
  endtask
endmodule

// ==== bench/sfr_paging_and_page_stack_test.sv ====
`timescale 1ns/1ps
module sfr_paging_and_page_stack_test;
  // one table row: access, then expected read byte and decode flags
  typedef struct packed {
    logic w;
    logic b;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] q;
    logic [3:0] f;
  } spg_row_s;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic acc_direct, acc_write, acc_read, acc_bit, int_entry, interrupt_return;
  logic [7:0] acc_addr, acc_wdata, int_page, acc_rdata_r, periph_page_r, periph_addr_r;
  logic [2:0] acc_bit_pos;
  logic sfr_sel_r, ram_sel_r, bit_ok_r, bit_refused_r, periph_sel_r, page_known_r;
  logic [7:0] page_select_r, page_stack_middle_r, page_stack_bottom_r;
  logic auto_page_enable_r;
  int error_cnt = 0;
  int num_checks = 0;
  // flags are {sfr, ram, bit ok, bit refused}
  spg_row_s rows [12] = '{
    '{1'b1, 1'b0, 8'hA7, 8'h0F, 8'h00, 4'h8}, '{1'b1, 1'b0, 8'h8E, 8'hFF, 8'h00, 4'h8},
    '{1'b0, 1'b0, 8'h8E, 8'h00, 8'h01, 4'h8}, '{1'b1, 1'b0, 8'h85, 8'h33, 8'h00, 4'h8},
    '{1'b0, 1'b0, 8'h85, 8'h00, 8'h33, 4'h8}, '{1'b1, 1'b0, 8'h86, 8'h44, 8'h00, 4'h8},
    '{1'b0, 1'b0, 8'h86, 8'h00, 8'h44, 4'h8}, '{1'b0, 1'b0, 8'h7F, 8'h00, 8'h00, 4'h4},
    '{1'b0, 1'b0, 8'h80, 8'h00, 8'h00, 4'h8}, '{1'b0, 1'b0, 8'hFF, 8'h00, 8'h00, 4'h8},
    '{1'b0, 1'b1, 8'h81, 8'h00, 8'h00, 4'h9}, '{1'b0, 1'b1, 8'h88, 8'h00, 8'h00, 4'hA}};

  ////////////////////////////////////////////////////////////////////////////////
  // design, core model and clock
  spg_sfr_pager dut_u (.sys_clk, .rst_n, .acc_direct, .acc_write, .acc_read, .acc_bit,
    .acc_addr, .acc_bit_pos, .acc_wdata, .int_entry, .interrupt_return, .int_page,
    .acc_rdata_r, .sfr_sel_r, .ram_sel_r, .bit_ok_r, .bit_refused_r, .periph_sel_r,
    .periph_page_r, .periph_addr_r, .page_known_r, .page_select_r, .page_stack_middle_r,
    .page_stack_bottom_r, .auto_page_enable_r);
  spg_core_model core_u (.sys_clk, .acc_direct, .acc_write, .acc_read, .acc_bit,
    .acc_addr, .acc_bit_pos, .acc_wdata, .int_entry, .interrupt_return, .int_page);
  always #5 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////////
  // compare and verdict
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("checks %0d, errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 200 cycles
  initial begin
    #100000;
    error_cnt++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    chk(page_select_r, 8'h00);
    chk(page_stack_middle_r, 8'h00);
    chk(page_stack_bottom_r, 8'h00);
    chk({7'h0, auto_page_enable_r}, 8'h01);
    // table of plain accesses
    foreach (rows[i]) begin
      core_u.access(rows[i].w, rows[i].b, rows[i].a, rows[i].d);
      chk({4'h0, sfr_sel_r, ram_sel_r, bit_ok_r, bit_refused_r}, {4'h0, rows[i].f});
      if (!rows[i].w) chk(acc_rdata_r, rows[i].q);
    end
    // software writes leave the stack in place
    chk(page_select_r, 8'h0F);
    chk(page_stack_middle_r, 8'h33);
    // push with auto paging, bottom written earlier is lost
    core_u.entry(8'h00);
    chk(page_select_r, 8'h00);
    chk(page_stack_middle_r, 8'h0F);
    chk(page_stack_bottom_r, 8'h33);
    // altered middle entry is what the pop restores
    core_u.access(1'b1, 1'b0, 8'h85, 8'h21);
    core_u.ret();
    chk(page_select_r, 8'h21);
    chk(page_stack_middle_r, 8'h33);
    core_u.ret();
    chk(page_select_r, 8'h33);
    chk(page_stack_middle_r, 8'h00);
    // unimplemented page: stack registers still reachable, others go out
    core_u.access(1'b1, 1'b0, 8'hA7, 8'h05);
    core_u.access(1'b0, 1'b0, 8'hA7, 8'h00);
    chk(acc_rdata_r, 8'h05);
    core_u.access(1'b0, 1'b0, 8'h90, 8'h00);
    chk({6'h0, periph_sel_r, page_known_r}, 8'h02);
    chk(periph_page_r, 8'h05);
    chk(periph_addr_r, 8'h90);
    // control register is absent on page 0x00
    core_u.access(1'b1, 1'b0, 8'hA7, 8'h00);
    core_u.access(1'b0, 1'b0, 8'h8E, 8'h00);
    chk({6'h0, periph_sel_r, page_known_r}, 8'h03);
    // auto paging off: entry and return change nothing
    core_u.access(1'b1, 1'b0, 8'hA7, 8'h0F);
    core_u.access(1'b1, 1'b0, 8'h8E, 8'h00);
    core_u.access(1'b1, 1'b0, 8'h85, 8'h77);
    chk({7'h0, auto_page_enable_r}, 8'h00);
    core_u.entry(8'h5A);
    chk(page_select_r, 8'h0F);
    chk(page_stack_middle_r, 8'h77);
    core_u.ret();
    chk(page_select_r, 8'h0F);
    // mid-run reset brings auto paging back on and clears the stack
    rst_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    chk({7'h0, auto_page_enable_r}, 8'h01);
    chk(page_select_r, 8'h00);
    chk(page_stack_middle_r, 8'h00);
    test_done();
  end
endmodule
